// *** core/hsv_pkg.sv ***
// constants for the headphone startup and volume register block
package hsv_pkg;
  localparam logic [7:0] HSV_PAGE = 8'h01;
  localparam logic [7:0] HSV_OFS_STARTUP = 8'h14;
  localparam logic [7:0] HSV_OFS_RSVD = 8'h15;
  localparam logic [7:0] HSV_OFS_VOLUME = 8'h16;
  localparam logic [7:0] HSV_RST_STARTUP = 8'h00;
  localparam logic [7:0] HSV_RST_RSVD = 8'h00;
  localparam logic [6:0] HSV_RST_VOLUME = 7'h00;
  // startup control and volume field positions
  localparam int HSV_STEP_HI = 7;
  localparam int HSV_STEP_LO = 6;
  localparam int HSV_PWR_HI = 5;
  localparam int HSV_PWR_LO = 2;
  localparam int HSV_RES_HI = 1;
  localparam int HSV_RES_LO = 0;
  localparam int HSV_VOL_HI = 6;
  // step times in ms
  localparam logic [7:0] HSV_STEP_MS_0 = 8'h00;
  localparam logic [7:0] HSV_STEP_MS_1 = 8'h32;
  localparam logic [7:0] HSV_STEP_MS_2 = 8'h64;
  localparam logic [7:0] HSV_STEP_MS_3 = 8'hc8;
  // charge resistance codes and values in kilo-ohm
  localparam logic [1:0] HSV_RES_25K = 2'h0;
  localparam logic [1:0] HSV_RES_6K = 2'h1;
  localparam logic [1:0] HSV_RES_2K = 2'h2;
  localparam logic [1:0] HSV_RES_BAD = 2'h3;
  localparam logic [5:0] HSV_KOHM_25 = 6'h19;
  localparam logic [5:0] HSV_KOHM_6 = 6'h06;
  localparam logic [5:0] HSV_KOHM_2 = 6'h02;
  // power-up codes: off, and first code that 25K forbids
  localparam logic [3:0] HSV_PWR_OFF = 4'h0;
  localparam logic [3:0] HSV_PWR_LONG = 4'hd;
  // attenuation table covers codes below this one
  localparam logic [6:0] HSV_VOL_TABLE_END = 7'h28;
  localparam logic [9:0] HSV_ATTEN_UNLISTED = 10'h3ff;
  localparam logic [7:0] HSV_READ_ZERO = 8'h00;
endpackage : hsv_pkg

// *** core/hsv_regs.sv ***
// headphone startup control and volume register bank
// What this block does
// R01: step field bits 7:6 selects 0, 50, 100 or 200 ms soft-routing step.
// R02: power-up field 0000 powers headphone amp without the slow ramp.
// R03: power-up codes 1..12 select 0.5 up to 8 time constants.
// R04: codes 13..15 give 16, 24, 32; host avoids them with 25K.
// R05: resistance field selects 25K, 6K, 2K; host never writes code 11.
// R06: reserved register after startup reads zero; host writes only default.
// R07: volume bit 7 is reserved, read-only, reads zero.
// R08: volume field bits 6:0 resets to zero, 0.0 dB; early steps 0.5 dB.
// R09: volume code maps to attenuation through a fixed lookup table.
// R10: writable fields hold and read back the last written value.
`timescale 1ns/1ps
module hsv_regs
  import hsv_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port behind the serial control interface
  input wire logic [7:0] page_sel,
  input wire logic [7:0] reg_addr,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // decoded settings toward the analog path
  output logic [7:0] step_time_ms,
  output logic slow_ramp_en,
  output logic [15:0] ramp_tc_milli,
  output logic [5:0] charge_kohm,
  output logic cfg_invalid,
  output logic [9:0] hp_atten_tenth_db,
  output logic hp_atten_listed
);

  logic [7:0] startup;
  logic [6:0] volume;
  logic page_hit;
  logic wr_startup;
  logic wr_volume;

  assign page_hit = (page_sel == HSV_PAGE);
  assign wr_startup = wr_en && page_hit && (reg_addr == HSV_OFS_STARTUP);
  assign wr_volume = wr_en && page_hit && (reg_addr == HSV_OFS_VOLUME);

  function automatic logic [7:0] step_ms(input logic [1:0] code);
    unique case (code)
      2'h0: step_ms = HSV_STEP_MS_0;
      2'h1: step_ms = HSV_STEP_MS_1;
      2'h2: step_ms = HSV_STEP_MS_2;
      2'h3: step_ms = HSV_STEP_MS_3;
    endcase
  endfunction : step_ms

  // durations in thousandths of a time constant
  function automatic logic [15:0] tc_milli(input logic [3:0] code);
    unique case (code)
      4'h0: tc_milli = 16'h0000;
      4'h1: tc_milli = 16'h01f4;
      4'h2: tc_milli = 16'h0271;
      4'h3: tc_milli = 16'h02d5;
      4'h4: tc_milli = 16'h036b;
      4'h5: tc_milli = 16'h03e8;
      4'h6: tc_milli = 16'h07d0;
      4'h7: tc_milli = 16'h0bb8;
      4'h8: tc_milli = 16'h0fa0;
      4'h9: tc_milli = 16'h1388;
      4'ha: tc_milli = 16'h1770;
      4'hb: tc_milli = 16'h1b58;
      4'hc: tc_milli = 16'h1f40;
      4'hd: tc_milli = 16'h3e80;
      4'he: tc_milli = 16'h5dc0;
      4'hf: tc_milli = 16'h7d00;
    endcase
  endfunction : tc_milli

  function automatic logic [5:0] kohm(input logic [1:0] code);
    unique case (code)
      HSV_RES_25K: kohm = HSV_KOHM_25;
      HSV_RES_6K: kohm = HSV_KOHM_6;
      HSV_RES_2K: kohm = HSV_KOHM_2;
      HSV_RES_BAD: kohm = HSV_KOHM_25;
    endcase
  endfunction : kohm

  // table kept as printed, repeated steps included; not a formula
  function automatic logic [9:0] atten(input logic [6:0] code);
    logic [9:0] t [0:39];
    t = '{10'd0, 10'd5, 10'd10, 10'd15, 10'd20, 10'd25, 10'd30, 10'd35,
          10'd40, 10'd40, 10'd50, 10'd55, 10'd60, 10'd65, 10'd70, 10'd75,
          10'd80, 10'd85, 10'd90, 10'd90, 10'd100, 10'd105, 10'd110, 10'd115,
          10'd120, 10'd125, 10'd130, 10'd135, 10'd141, 10'd146, 10'd151,
          10'd156, 10'd160, 10'd165, 10'd171, 10'd175, 10'd181, 10'd186,
          10'd191, 10'd191};
    if (code < HSV_VOL_TABLE_END) begin
      atten = t[code[5:0]];
    end else begin
      atten = HSV_ATTEN_UNLISTED;
    end
  endfunction : atten

  // startup control storage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      startup <= HSV_RST_STARTUP;
    end else if (wr_startup) begin
      startup <= wr_data; // R10
    end
  end

  // volume storage; bit 7 is never stored
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      volume <= HSV_RST_VOLUME; // R08
    end else if (wr_volume) begin
      volume <= wr_data[HSV_VOL_HI:0]; // R07 R10
    end
  end

  // read path, one cycle latency; other addresses read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data <= HSV_READ_ZERO;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en && page_hit && reg_addr == HSV_OFS_STARTUP) begin
        rd_data <= startup; // R10
      end else if (rd_en && page_hit && reg_addr == HSV_OFS_VOLUME) begin
        rd_data <= {1'b0, volume}; // R07
      end else begin
        rd_data <= HSV_READ_ZERO; // R06
      end
    end
  end

  // decoded startup settings
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      step_time_ms <= HSV_STEP_MS_0;
      slow_ramp_en <= 1'b0;
      ramp_tc_milli <= '0;
      charge_kohm <= HSV_KOHM_25;
      cfg_invalid <= 1'b0;
    end else begin
      step_time_ms <= step_ms(startup[HSV_STEP_HI:HSV_STEP_LO]); // R01
      slow_ramp_en <= startup[HSV_PWR_HI:HSV_PWR_LO] != HSV_PWR_OFF; // R02
      ramp_tc_milli <= tc_milli(startup[HSV_PWR_HI:HSV_PWR_LO]); // R03 R04
      charge_kohm <= kohm(startup[HSV_RES_HI:HSV_RES_LO]); // R05
      // flags host misuse only; the analog side still gets a value
      cfg_invalid <= (startup[HSV_RES_HI:HSV_RES_LO] == HSV_RES_BAD) ||
        ((startup[HSV_RES_HI:HSV_RES_LO] == HSV_RES_25K) &&
         (startup[HSV_PWR_HI:HSV_PWR_LO] >= HSV_PWR_LONG)); // R04 R05
    end
  end

  // volume attenuation lookup
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hp_atten_tenth_db <= '0;
      hp_atten_listed <= 1'b1;
    end else begin
      hp_atten_tenth_db <= atten(volume); // R09
      hp_atten_listed <= volume < HSV_VOL_TABLE_END;
    end
  end

  step_time_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_startup && wr_data[HSV_STEP_HI:HSV_STEP_LO] == 2'h3
    |=> ##1 step_time_ms == HSV_STEP_MS_3)
    else $error("step time not 200 ms"); // R01

  ramp_off_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_startup && wr_data[HSV_PWR_HI:HSV_PWR_LO] == HSV_PWR_OFF
    |=> ##1 !slow_ramp_en && ramp_tc_milli == 16'h0000)
    else $error("slow ramp not disabled"); // R02

  ramp_half_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_startup && wr_data[HSV_PWR_HI:HSV_PWR_LO] == 4'h1
    |=> ##1 slow_ramp_en && ramp_tc_milli == 16'h01f4)
    else $error("ramp not half constant"); // R03

  long_ramp_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_startup && wr_data[HSV_PWR_HI:HSV_PWR_LO] == 4'hf &&
    wr_data[HSV_RES_HI:HSV_RES_LO] == HSV_RES_25K
    |=> ##1 cfg_invalid && ramp_tc_milli == 16'h7d00)
    else $error("long ramp with 25K not flagged"); // R04

  charge_res_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_startup && wr_data[HSV_RES_HI:HSV_RES_LO] == HSV_RES_2K
    |=> ##1 charge_kohm == HSV_KOHM_2)
    else $error("charge resistance not 2K"); // R05

  rsvd_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    rd_en && page_hit && reg_addr == HSV_OFS_RSVD |=> rd_valid && rd_data == 8'h00)
    else $error("reserved register not zero"); // R06

  vol_msb_a: assert property (@(posedge core_clk) disable iff (rst)
    rd_en && page_hit && reg_addr == HSV_OFS_VOLUME |=> !rd_data[7])
    else $error("volume bit 7 not zero"); // R07

  vol_example_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_volume && wr_data[HSV_VOL_HI:0] == 7'h1c ##1 !wr_volume
    |=> hp_atten_tenth_db == 10'd141)
    else $error("volume 0x1c not 14.1 dB"); // R09

  vol_step_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_volume && wr_data[HSV_VOL_HI:0] == 7'h01 ##1 !wr_volume
    |=> hp_atten_tenth_db == 10'd5)
    else $error("first volume step not 0.5 dB"); // R08

  // a read on the very next edge must already see the new byte
  sequence startup_wr_then_rd_s;
    wr_startup ##1 (rd_en && !wr_en && page_hit && reg_addr == HSV_OFS_STARTUP);
  endsequence

  readback_a: assert property (@(posedge core_clk) disable iff (rst)
    startup_wr_then_rd_s |=> rd_data == $past(wr_data, 2))
    else $error("startup readback mismatch"); // R10

endmodule : hsv_regs

// *** dv/hsv_host.sv ***
// host model driving the register port
`timescale 1ns/1ps
module hsv_host
  import hsv_pkg::*;
(
  // clock
  input wire logic core_clk,
  // register port
  output logic [7:0] page_sel,
  output logic [7:0] reg_addr,
  output logic wr_en,
  output logic [7:0] wr_data,
  output logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  initial begin
    page_sel = HSV_PAGE;
    reg_addr = 8'h00;
    wr_en = 1'b0;
    wr_data = 8'h00;
    rd_en = 1'b0;
  end
  // extra idle cycle so decoded outputs have landed
  task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    page_sel = pg;
    reg_addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge core_clk);
    wr_en = 1'b0;
    wr_data = ~d; // released data must not look valid
    @(negedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge core_clk);
    page_sel = HSV_PAGE;
    reg_addr = a;
    rd_en = 1'b1;
    @(negedge core_clk);
    rd_en = 1'b0;
    d = rd_data;
    v = rd_valid;
  endtask : rd
  // write, then read the same offset on the next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] q,
                       output logic v);
    @(negedge core_clk);
    page_sel = HSV_PAGE;
    reg_addr = a;
    wr_data = wd;
    wr_en = 1'b1;
    @(negedge core_clk);
    wr_en = 1'b0;
    rd_en = 1'b1;
    @(negedge core_clk);
    rd_en = 1'b0;
    q = rd_data;
    v = rd_valid;
  endtask : wr_rd
endmodule : hsv_host

// *** dv/hsv_regs_tb.sv ***
// self-checking bench for the register block
`timescale 1ns/1ps
module hsv_regs_tb;
  import hsv_pkg::*;
  logic core_clk, rst, wr_en, rd_en, rd_valid, slow_ramp_en, cfg_invalid, hp_atten_listed;
  logic rv;
  logic [7:0] page_sel, reg_addr, wr_data, rd_data, step_time_ms, d, q;
  logic [15:0] ramp_tc_milli;
  logic [5:0] charge_kohm;
  logic [9:0] hp_atten_tenth_db;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int tc[16] = '{0, 500, 625, 725, 875, 1000, 2000, 3000, 4000, 5000, 6000, 7000, 8000,
                 16000, 24000, 32000};
  logic [7:0] st[4] = '{HSV_STEP_MS_0, HSV_STEP_MS_1, HSV_STEP_MS_2, HSV_STEP_MS_3};
  logic [5:0] ko[4] = '{HSV_KOHM_25, HSV_KOHM_6, HSV_KOHM_2, HSV_KOHM_25};
  logic [6:0] vc[8] = '{7'h00, 7'h01, 7'h09, 7'h13, 7'h1c, 7'h20, 7'h26, 7'h27};
  int va[8] = '{0, 5, 40, 90, 141, 160, 191, 191};
  hsv_regs i_dut (.core_clk(core_clk), .rst(rst), .page_sel(page_sel), .reg_addr(reg_addr),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
    .step_time_ms(step_time_ms), .slow_ramp_en(slow_ramp_en), .ramp_tc_milli(ramp_tc_milli),
    .charge_kohm(charge_kohm), .cfg_invalid(cfg_invalid),
    .hp_atten_tenth_db(hp_atten_tenth_db), .hp_atten_listed(hp_atten_listed));
  hsv_host i_host (.core_clk(core_clk), .page_sel(page_sel), .reg_addr(reg_addr),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic v;
    i_host.rd(a, q, v);
    chk(v, 1'b1);
    chk(q, exp);
  endtask : rchk
  task automatic end_of_test();
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // run is under two hundred cycles; ceiling leaves ample margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    rchk(HSV_OFS_STARTUP, 8'h00);
    rchk(HSV_OFS_RSVD, 8'h00);
    rchk(HSV_OFS_VOLUME, 8'h00);
    chk(slow_ramp_en, 1'b0);
    chk(charge_kohm, HSV_KOHM_25);
    for (int i = 0; i < 16; i++) begin
      d = {i[1:0], i[3:0], HSV_RES_6K};
      i_host.wr(HSV_PAGE, HSV_OFS_STARTUP, d);
      chk(step_time_ms, st[i[1:0]]);
      chk(slow_ramp_en, i != 0);
      chk(ramp_tc_milli, 16'(tc[i]));
      chk(cfg_invalid, 1'b0);
      rchk(HSV_OFS_STARTUP, d);
    end
    for (int r = 0; r < 4; r++) begin
      i_host.wr(HSV_PAGE, HSV_OFS_STARTUP, {6'h01, r[1:0]});
      chk(charge_kohm, ko[r]);
      chk(cfg_invalid, r == 3);
    end
    // back-to-back write and read of the startup byte
    i_host.wr_rd(HSV_OFS_STARTUP, 8'h95, q, rv);
    chk(rv, 1'b1);
    chk(q, 8'h95);
    // long ramp with 25K deliberately broken by the host
    i_host.wr(HSV_PAGE, HSV_OFS_STARTUP, {2'h0, HSV_PWR_LONG, HSV_RES_25K});
    chk(cfg_invalid, 1'b1);
    i_host.wr(HSV_PAGE, HSV_OFS_STARTUP, {2'h0, 4'hf, HSV_RES_25K});
    chk(cfg_invalid, 1'b1);
    chk(ramp_tc_milli, 16'(tc[15]));
    i_host.wr(HSV_PAGE, HSV_OFS_RSVD, 8'hff);
    rchk(HSV_OFS_RSVD, 8'h00);
    i_host.wr(HSV_PAGE, HSV_OFS_VOLUME, 8'hff);
    rchk(HSV_OFS_VOLUME, 8'h7f);
    chk(hp_atten_listed, 1'b0);
    chk(hp_atten_tenth_db, HSV_ATTEN_UNLISTED);
    for (int k = 0; k < 8; k++) begin
      i_host.wr(HSV_PAGE, HSV_OFS_VOLUME, {1'b0, vc[k]});
      chk(hp_atten_tenth_db, 10'(va[k]));
      chk(hp_atten_listed, 1'b1);
      rchk(HSV_OFS_VOLUME, {1'b0, vc[k]});
    end
    // other page must not disturb the held value
    i_host.wr(8'h02, HSV_OFS_VOLUME, 8'h11);
    rchk(HSV_OFS_VOLUME, {1'b0, vc[7]});
    @(negedge core_clk);
    rst = 1'b1;
    @(negedge core_clk);
    rst = 1'b0;
    rchk(HSV_OFS_VOLUME, 8'h00);
    chk(hp_atten_tenth_db, 10'h000);
    end_of_test();
  end
endmodule : hsv_regs_tb
